// file: rtl/rtcsr_defines.svh
`ifndef RTCSR_DEFINES_SVH
`define RTCSR_DEFINES_SVH

// Register offsets
`define RTCSR_OFF_CTRL        8'h0E
`define RTCSR_OFF_STATUS      8'h0F
`define RTCSR_OFF_AGING       8'h10
`define RTCSR_OFF_TEMP_INT    8'h11
`define RTCSR_OFF_TEMP_FRAC   8'h12
`define RTCSR_OFF_RAM_FIRST   8'h14

// Status bit positions
`define RTCSR_B_HALT          7
`define RTCSR_B_BATT_REF      6
`define RTCSR_B_RATE_HI       5
`define RTCSR_B_RATE_LO       4
`define RTCSR_B_REF_EN        3
`define RTCSR_B_BUSY          2
`define RTCSR_B_ALM2          1
`define RTCSR_B_ALM1          0

// Control bit positions
`define RTCSR_C_OSC_DIS       7
`define RTCSR_C_CONVERSION_REQUEST          5
`define RTCSR_C_IRQ_MODE      2
`define RTCSR_C_ALM2_IE       1
`define RTCSR_C_ALM1_IE       0

// Reset values
`define RTCSR_RST_STATUS      8'h88
`define RTCSR_RST_CTRL        8'h1C
`define RTCSR_RST_ZERO        8'h00
`define RTCSR_FRAC_MASK       8'hC0

// Timing: oscillator ticks per second and base interval
`define RTCSR_TICKS_PER_SEC   16'h8000
`define RTCSR_BASE_SECONDS    12'h040
`define RTCSR_RAM_DEPTH       236

`endif

// file: rtl/rtcsr_pkg.sv
package rtcsr_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcsr_req_s;

    typedef struct packed {
        logic       done;
        logic [9:0] code;
    } rtcsr_temp_s;

    typedef enum logic [1:0] {
        RTCSR_IDLE = 2'b00,
        RTCSR_CONVERSION_REQUEST = 2'b01,
        RTCSR_COMP = 2'b11
    } rtcsr_conversion_request_e;

endpackage

// file: rtl/rtcsr_ram.sv
`timescale 1ns/1ps
`include "rtcsr_defines.svh"

module rtcsr_ram
(
    // Clock
    input  wire logic       clk_sys,
    input  wire logic       ce,
    // Access
    input  wire logic       we,
    input  wire logic [7:0] idx,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    logic [7:0] mem_r [0:`RTCSR_RAM_DEPTH-1];

    // No reset: contents undefined after power-up
    always_ff @(posedge clk_sys)
    begin
        if (ce && we)
        begin
            mem_r[idx] <= wdata; // [RULE_26]
        end
    end

    assign rdata = mem_r[idx];

endmodule // rtcsr_ram

// file: rtl/rtcsr_regs.sv
`timescale 1ns/1ps
`include "rtcsr_defines.svh"

// Contract
// [RULE_01] Halt flag set whenever oscillator stops
// [RULE_02] Halt flag set at first power
// [RULE_03] Oscillator disabled on battery sets halt flag
// [RULE_04] Halt flag holds until written zero
// [RULE_05] Battery mode reference output needs both enables
// [RULE_06] Rate field picks 64/128/256/512 s interval
// [RULE_07] New rate may take one interval
// [RULE_08] Reference enable gates 32kHz square wave
// [RULE_09] Reference enable resets to one
// [RULE_10] Busy set on conversion, cleared when done
// [RULE_11] Second alarm sets flag, maybe interrupt
// [RULE_12] First alarm sets flag, maybe interrupt
// [RULE_13] Alarm flags clear by zero, ignore one
// [RULE_14] Aging trim signed, added to capacitance
// [RULE_15] Trim applied on changed or manual conversion
// [RULE_16] Positive trim adds capacitance, negative removes
// [RULE_17] Host converts manually after trim change
// [RULE_18] Temperature ten bits, quarter degree steps
// [RULE_19] Reset loads zero and starts conversion
// [RULE_20] Measure at power, battery access, periodically
// [RULE_21] Temperature registers are read only
// [RULE_22] Conversion request holds until conversion ends
// [RULE_23] Irq mode selects wave or alarm interrupt
// [RULE_24] Oscillator disable only acts on battery
// [RULE_25] Writes to temperature bytes ignored
// [RULE_26] User RAM 14h..FFh read/write storage
module rtcsr_regs
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // Register access from serial engine
    input  rtcsr_pkg::rtcsr_req_s        req,
    output logic                  [7:0]  rdata_r,
    // Oscillator and supply
    input  wire logic                    osc_clk,
    input  wire logic                    osc_fail,
    input  wire logic                    on_battery,
    // Alarm match pulses and square wave source
    input  wire logic                    alarm1_match,
    input  wire logic                    alarm2_match,
    input  wire logic                    sqw_src,
    // Temperature sensor
    output logic                         sensor_start_r,
    input  rtcsr_pkg::rtcsr_temp_s       sensor,
    // Capacitance array
    input  wire logic             [7:0]  cap_calc,
    output logic                  [7:0]  cap_array_r,
    // Pins
    output logic                         ref_out_r,
    output logic                         irq_or_wave_pin_r,
    output logic                         irq_or_wave_oe_n_r,
    output logic                         osc_run_r
);

    //**********************************************************
    // Input synchronisers
    //**********************************************************
    logic [2:0] osc_sync_r;
    logic [1:0] fail_sync_r;
    logic [1:0] batt_sync_r;
    logic       osc_s;
    logic       osc_rise;
    logic       fail_s;
    logic       batt_s;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            osc_sync_r  <= 3'h0;
            fail_sync_r <= 2'h0;
            batt_sync_r <= 2'h0;
        end
        else if (ce)
        begin
            osc_sync_r  <= {osc_sync_r[1:0], osc_clk};
            fail_sync_r <= {fail_sync_r[0], osc_fail};
            batt_sync_r <= {batt_sync_r[0], on_battery};
        end
    end

    assign osc_s    = osc_sync_r[1];
    assign osc_rise = osc_sync_r[1] & ~osc_sync_r[2];
    assign fail_s   = fail_sync_r[1];
    assign batt_s   = batt_sync_r[1];

    //**********************************************************
    // Decode
    //**********************************************************
    function automatic logic hit(input logic [7:0] off);
        hit = req.valid && req.write && (req.addr == off);
    endfunction

    logic wr_ctrl;
    logic wr_stat;
    logic wr_aging;
    logic wr_ram;
    logic in_ram;

    assign wr_ctrl  = hit(`RTCSR_OFF_CTRL);
    assign wr_stat  = hit(`RTCSR_OFF_STATUS);
    assign wr_aging = hit(`RTCSR_OFF_AGING);
    assign in_ram   = (req.addr >= `RTCSR_OFF_RAM_FIRST);
    assign wr_ram   = req.valid && req.write && in_ram;

    //**********************************************************
    // Control and status registers
    //**********************************************************
    logic [7:0]              ctrl_r;
    logic [7:0]              stat_r;
    logic [7:0]              aging_r;
    logic [9:0]              temp_r;
    logic                    conversion_request_end;
    logic                    osc_stop;
    rtcsr_pkg::rtcsr_conversion_request_e  st_r;

    // Oscillator stops on battery with disable set, or on oscillator failure
    assign osc_stop = (batt_s && ctrl_r[`RTCSR_C_OSC_DIS]) || fail_s; // [RULE_24]

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `RTCSR_RST_CTRL;
        end
        else if (ce)
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= req.wdata;
                // Request bit sticks while conversion runs
                if (ctrl_r[`RTCSR_C_CONVERSION_REQUEST] && !conversion_request_end)
                begin
                    ctrl_r[`RTCSR_C_CONVERSION_REQUEST] <= 1'b1; // [RULE_22]
                end
            end
            if (conversion_request_end)
            begin
                ctrl_r[`RTCSR_C_CONVERSION_REQUEST] <= 1'b0; // [RULE_22]
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stat_r <= `RTCSR_RST_STATUS; // [RULE_02] [RULE_09]
        end
        else if (ce)
        begin
            if (wr_stat)
            begin
                stat_r[`RTCSR_B_BATT_REF] <= req.wdata[`RTCSR_B_BATT_REF];
                stat_r[`RTCSR_B_RATE_HI]  <= req.wdata[`RTCSR_B_RATE_HI];
                stat_r[`RTCSR_B_RATE_LO]  <= req.wdata[`RTCSR_B_RATE_LO];
                stat_r[`RTCSR_B_REF_EN]   <= req.wdata[`RTCSR_B_REF_EN];
                // Halt flag: only zero writes take effect
                stat_r[`RTCSR_B_HALT] <= stat_r[`RTCSR_B_HALT] & req.wdata[`RTCSR_B_HALT]; // [RULE_04]
                stat_r[`RTCSR_B_ALM2] <= stat_r[`RTCSR_B_ALM2] & req.wdata[`RTCSR_B_ALM2]; // [RULE_13]
                stat_r[`RTCSR_B_ALM1] <= stat_r[`RTCSR_B_ALM1] & req.wdata[`RTCSR_B_ALM1]; // [RULE_13]
            end
            // Hardware sets win over clears
            if (osc_stop)
            begin
                stat_r[`RTCSR_B_HALT] <= 1'b1; // [RULE_01] [RULE_03]
            end
            if (alarm2_match)
            begin
                stat_r[`RTCSR_B_ALM2] <= 1'b1; // [RULE_11]
            end
            if (alarm1_match)
            begin
                stat_r[`RTCSR_B_ALM1] <= 1'b1; // [RULE_12]
            end
            stat_r[`RTCSR_B_BUSY] <= (st_r != rtcsr_pkg::RTCSR_IDLE); // [RULE_10]
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aging_r <= `RTCSR_RST_ZERO;
        end
        else if (ce && wr_aging)
        begin
            aging_r <= req.wdata;
        end
    end

    //**********************************************************
    // Conversion scheduler
    //**********************************************************
    logic [15:0] tick_r;
    logic [11:0] sec_r;
    logic [11:0] period;
    logic        periodic;
    logic        batt_access;
    logic        start_req;
    logic        manual_r;
    logic        boot_r;

    // Interval doubles per rate step
    assign period = `RTCSR_BASE_SECONDS << stat_r[`RTCSR_B_RATE_HI:`RTCSR_B_RATE_LO]; // [RULE_06]
    assign periodic    = (sec_r >= period - 12'h001) && osc_rise
                         && (tick_r == `RTCSR_TICKS_PER_SEC - 16'h0001);
    assign batt_access = batt_s && req.valid;
    assign start_req   = boot_r || periodic || batt_access
                         || ctrl_r[`RTCSR_C_CONVERSION_REQUEST]; // [RULE_20]
    assign conversion_request_end    = (st_r == rtcsr_pkg::RTCSR_COMP);

    // Counter keeps running; a new rate is compared against the running count at the next second
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tick_r <= 16'h0000;
            sec_r  <= 12'h000;
        end
        else if (ce && osc_rise)
        begin
            tick_r <= tick_r + 16'h0001;
            if (tick_r == `RTCSR_TICKS_PER_SEC - 16'h0001)
            begin
                tick_r <= 16'h0000;
                sec_r  <= periodic ? 12'h000 : sec_r + 12'h001; // [RULE_07]
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_r           <= rtcsr_pkg::RTCSR_IDLE;
            sensor_start_r <= 1'b0;
            manual_r       <= 1'b0;
            boot_r         <= 1'b1; // [RULE_19]
        end
        else if (ce)
        begin
            sensor_start_r <= 1'b0;
            case (st_r)
                rtcsr_pkg::RTCSR_IDLE:
                begin
                    if (start_req)
                    begin
                        st_r           <= rtcsr_pkg::RTCSR_CONVERSION_REQUEST;
                        sensor_start_r <= 1'b1; // [RULE_10]
                        manual_r       <= ctrl_r[`RTCSR_C_CONVERSION_REQUEST];
                        boot_r         <= 1'b0;
                    end
                end
                rtcsr_pkg::RTCSR_CONVERSION_REQUEST:
                begin
                    if (sensor.done)
                    begin
                        st_r <= rtcsr_pkg::RTCSR_COMP;
                    end
                end
                rtcsr_pkg::RTCSR_COMP:
                begin
                    st_r <= rtcsr_pkg::RTCSR_IDLE;
                end
                default:
                begin
                    st_r <= rtcsr_pkg::RTCSR_IDLE;
                end
            endcase
        end
    end

    //**********************************************************
    // Temperature and capacitance
    //**********************************************************
    logic [9:0] new_code_r;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            temp_r     <= 10'h000; // [RULE_19]
            new_code_r <= 10'h000;
        end
        else if (ce && st_r == rtcsr_pkg::RTCSR_CONVERSION_REQUEST && sensor.done)
        begin
            new_code_r <= sensor.code;
        end
        else if (ce && conversion_request_end)
        begin
            temp_r <= new_code_r; // [RULE_18] [RULE_20]
        end
    end

    // Signed trim: positive adds units, negative removes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cap_array_r <= `RTCSR_RST_ZERO;
        end
        else if (ce && conversion_request_end && (manual_r || new_code_r != temp_r)) // [RULE_15]
        begin
            cap_array_r <= cap_calc + aging_r; // [RULE_14] [RULE_16]
        end
    end

    //**********************************************************
    // Pins
    //**********************************************************
    logic ref_allow;
    logic irq_act;

    assign ref_allow = stat_r[`RTCSR_B_REF_EN]
                       && (!batt_s || stat_r[`RTCSR_B_BATT_REF]); // [RULE_05] [RULE_08]
    assign irq_act = (stat_r[`RTCSR_B_ALM1] && ctrl_r[`RTCSR_C_ALM1_IE])
                     || (stat_r[`RTCSR_B_ALM2] && ctrl_r[`RTCSR_C_ALM2_IE]);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ref_out_r          <= 1'b0;
            irq_or_wave_pin_r  <= 1'b1;
            irq_or_wave_oe_n_r <= 1'b1;
            osc_run_r          <= 1'b0;
        end
        else if (ce)
        begin
            osc_run_r <= !osc_stop;
            ref_out_r <= ref_allow && !osc_stop && osc_s; // [RULE_08]
            if (ctrl_r[`RTCSR_C_IRQ_MODE])
            begin
                // Open-drain active-low interrupt
                irq_or_wave_pin_r  <= 1'b0;
                irq_or_wave_oe_n_r <= !irq_act; // [RULE_11] [RULE_12] [RULE_23]
            end
            else
            begin
                irq_or_wave_pin_r  <= 1'b0;
                irq_or_wave_oe_n_r <= sqw_src; // [RULE_23]
            end
        end
    end

    //**********************************************************
    // Read path
    //**********************************************************
    logic [7:0] ram_rd;

    rtcsr_ram u_ram
    (
        .clk_sys (clk_sys),
        .ce      (ce),
        .we      (wr_ram),
        .idx     (req.addr - `RTCSR_OFF_RAM_FIRST),
        .wdata   (req.wdata),
        .rdata   (ram_rd)
    );

    // Temperature bytes have no write path
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_r <= `RTCSR_RST_ZERO;
        end
        else if (ce && req.valid && !req.write)
        begin
            case (req.addr)
                `RTCSR_OFF_CTRL:      rdata_r <= ctrl_r;
                `RTCSR_OFF_STATUS:    rdata_r <= stat_r;
                `RTCSR_OFF_AGING:     rdata_r <= aging_r;
                `RTCSR_OFF_TEMP_INT:  rdata_r <= temp_r[9:2]; // [RULE_21] [RULE_25]
                `RTCSR_OFF_TEMP_FRAC: rdata_r <= {temp_r[1:0], 6'h00} & `RTCSR_FRAC_MASK; // [RULE_18]
                default:              rdata_r <= in_ram ? ram_rd : `RTCSR_RST_ZERO;
            endcase
        end
    end

endmodule // rtcsr_regs

// file: bench/rtcsr_regs_sva.sv
`timescale 1ns/1ps
module rtcsr_regs_sva
(
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   ce,
    // Access
    input rtcsr_pkg::rtcsr_req_s       req,
    input wire logic             [7:0] rdata_r,
    // Events and pins
    input wire logic                   on_battery,
    input wire logic                   alarm1_match,
    input wire logic                   sensor_start_r,
    input rtcsr_pkg::rtcsr_temp_s      sensor,
    input wire logic             [7:0] cap_calc,
    input wire logic             [7:0] cap_array_r,
    input wire logic                   ref_out_r,
    input wire logic                   irq_or_wave_oe_n_r
);
    logic       wr;
    logic       ref_en_r, bat_en_r, mode_r, ie1_r, ie2_r, busy_r;
    logic [7:0] trim_r;
    assign wr = ce && req.valid && req.write;
    // ****************************************
    // Shadow of written control state
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            {ref_en_r, bat_en_r, mode_r, ie1_r, ie2_r, trim_r} <= {5'h14, 8'h00};
        else if (wr && req.addr == 8'h0F)
            {ref_en_r, bat_en_r} <= {req.wdata[3], req.wdata[6]};
        else if (wr && req.addr == 8'h0E)
            {mode_r, ie2_r, ie1_r} <= req.wdata[2:0];
        else if (wr && req.addr == 8'h10)
            trim_r <= req.wdata;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            busy_r <= 1'b0;
        else if (sensor_start_r)
            busy_r <= 1'b1;
        else if (sensor.done)
            busy_r <= 1'b0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_frac_zero;
        ce && req.valid && !req.write && req.addr == 8'h12 |=> rdata_r[5:0] == 6'h00;
    endproperty
    a_frac_zero: assert property (p_frac_zero) else $error("fraction low bits set");
    property p_boot_conversion_request;
        $rose(rst_n) |-> ##[0:2] sensor_start_r;
    endproperty
    a_boot_conversion_request: assert property (p_boot_conversion_request) else $error("no boot conversion");
    property p_ref_off;
        (!ref_en_r) [*3] |-> !ref_out_r;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref output not low");
    property p_batt_off;
        (on_battery && !bat_en_r) [*5] |-> !ref_out_r;
    endproperty
    a_batt_off: assert property (p_batt_off) else $error("ref output on battery");
    property p_irq_idle;
        (mode_r && !ie1_r && !ie2_r) [*3] |-> irq_or_wave_oe_n_r;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq pin pulled");
    property p_alarm_irq;
        alarm1_match && mode_r && ie1_r |-> ##[1:3] !irq_or_wave_oe_n_r;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq missing");
    property p_trim_cap;
        $changed(cap_array_r) |-> cap_array_r == cap_calc + trim_r;
    endproperty
    a_trim_cap: assert property (p_trim_cap) else $error("cap array wrong");
    property p_manual_conversion_request;
        wr && req.addr == 8'h0E && req.wdata[5] && !busy_r |-> ##[1:3] sensor_start_r;
    endproperty
    a_manual_conversion_request: assert property (p_manual_conversion_request) else $error("no manual start");
    property p_no_restart;
        sensor_start_r |-> !busy_r;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while busy");
endmodule // rtcsr_regs_sva

bind rtcsr_regs rtcsr_regs_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req(req),
    .rdata_r(rdata_r), .on_battery(on_battery), .alarm1_match(alarm1_match),
    .sensor_start_r(sensor_start_r), .sensor(sensor), .cap_calc(cap_calc),
    .cap_array_r(cap_array_r), .ref_out_r(ref_out_r), .irq_or_wave_oe_n_r(irq_or_wave_oe_n_r));

// file: bench/rtcsr_sensor_model.sv
`timescale 1ns/1ps
module rtcsr_sensor_model
(
    // Clock
    input  wire logic                   clk_sys,
    // Settings from bench
    input  wire logic            [9:0]  code_in,
    input  wire logic            [7:0]  delay,
    // Sensor handshake
    input  wire logic                   start,
    output rtcsr_pkg::rtcsr_temp_s      sensor
);
    int         cnt  = -1;
    logic [9:0] last = 10'h000;
    always @(posedge clk_sys)
    begin
        sensor.done <= 1'b0;
        sensor.code <= ~last;
        if (start)
            cnt <= delay;
        else if (cnt == 0)
        begin
            sensor.done <= 1'b1;
            sensor.code <= code_in;
            last        <= code_in;
            cnt         <= -1;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule // rtcsr_sensor_model

// file: bench/rtcsr_regs_bench.sv
`timescale 1ns/1ps
module rtcsr_regs_bench;
    logic clk_sys = 0, rst_n = 0, ce = 1, osc_clk = 0, osc_fail = 0, on_battery = 0;
    logic alarm1_match = 0, alarm2_match = 0, sqw_src = 0, sensor_start_r, ref_out_r;
    logic irq_or_wave_pin_r, irq_or_wave_oe_n_r, osc_run_r;
    logic [7:0] cap_calc = 8'h40, delay = 8'h28, rdata_r, cap_array_r, st = 8'h8C, ct = 8'h04;
    logic [7:0] tr = 8'h00, ram [256];
    logic [9:0] code_in = 10'h064, tm = 10'h000;
    rtcsr_pkg::rtcsr_req_s  req = '0;
    rtcsr_pkg::rtcsr_temp_s sensor;
    int err_total = 0, compares = 0, seed = 32'hb6434115, i, n, t, q[$];
    rtcsr_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req(req), .rdata_r(rdata_r),
        .osc_clk(osc_clk), .osc_fail(osc_fail), .on_battery(on_battery),
        .alarm1_match(alarm1_match), .alarm2_match(alarm2_match), .sqw_src(sqw_src),
        .sensor_start_r(sensor_start_r), .sensor(sensor), .cap_calc(cap_calc),
        .cap_array_r(cap_array_r), .ref_out_r(ref_out_r), .irq_or_wave_pin_r(irq_or_wave_pin_r),
        .irq_or_wave_oe_n_r(irq_or_wave_oe_n_r), .osc_run_r(osc_run_r));
    rtcsr_sensor_model u_sensor (.clk_sys(clk_sys), .code_in(code_in), .delay(delay),
        .start(sensor_start_r), .sensor(sensor));
    initial forever #25 clk_sys = ~clk_sys;
    initial
    begin
        #7;
        forever #200 osc_clk = ~osc_clk;
    end
    always @(posedge clk_sys) sqw_src <= ~sqw_src;
    // ****************************************
    // Checking and access tasks
    // ****************************************
    task automatic give_verdict();
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] mdl(input logic [7:0] a);
        case (a)
            8'h0E:   return ct;
            8'h0F:   return st;
            8'h10:   return tr;
            8'h11:   return tm[9:2];
            8'h12:   return {tm[1:0], 6'h00};
            default: return (a >= 8'h14) ? ram[a] : 8'h00;
        endcase
    endfunction
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, w, a, d};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        @(posedge clk_sys);
        if (w && a == 8'h0F) st = (d & 8'h78) | (st & 8'h04) | (st & d & 8'h83);
        if (w && a == 8'h0E) ct = (d & 8'hA7) | (ct & 8'h20);
        if (w && a == 8'h10) tr = d;
        if (w && a >= 8'h14) ram[a] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m);
        acc(1'b0, a, 8'h00);
        chk(rdata_r & m, mdl(a) & m);
    endtask
    task automatic wait_done();
        n = 0;
        while (sensor.done !== 1'b1 && n < 300)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(8'(n < 300), 8'h01);
        repeat (3) @(posedge clk_sys);
        tm = code_in;
        st = st & 8'hFB;
        ct = ct & 8'hDF;
    endtask
    task automatic toggles();
        logic p;
        t = 0;
        @(posedge clk_sys);
        p = ref_out_r;
        repeat (40)
        begin
            @(posedge clk_sys);
            if (ref_out_r !== p) t++;
            p = ref_out_r;
        end
    endtask
    initial
    begin
        #5000000;
        err_total++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h11, 8'hFF);
        rd(8'h0F, 8'hFF);
        wait_done();
        rd(8'h0F, 8'hFF);
        rd(8'h0E, 8'hA7);
        rd(8'h10, 8'hFF);
        rd(8'h11, 8'hFF);
        rd(8'h12, 8'hFF);
        chk(cap_array_r, cap_calc + tr);
        toggles();
        chk(8'(t > 0), 8'h01);
        acc(1'b1, 8'h11, 8'($random(seed)));
        acc(1'b1, 8'h12, 8'($random(seed)));
        rd(8'h11, 8'hFF);
        rd(8'h12, 8'hFF);
        rd(8'h13, 8'hFF);
        q = '{8'h14, 8'hFF};
        for (i = 0; i < 8; i++) q.push_back(20 + ({$random(seed)} % 236));
        foreach (q[k]) acc(1'b1, 8'(q[k]), 8'($random(seed)));
        foreach (q[k]) rd(8'(q[k]), 8'hFF);
        for (i = 0; i < 4; i++)
        begin
            acc(1'b1, 8'h0F, 8'(8'h08 | (i << 4)));
            rd(8'h0F, 8'hFF);
        end
        for (i = 0; i < 2; i++)
        begin
            code_in  <= 10'($random(seed));
            cap_calc <= 8'($random(seed));
            acc(1'b1, 8'h10, (i == 0) ? 8'h05 : 8'hFB);
            acc(1'b1, 8'h0E, 8'h24);
            st = st | 8'h04;
            repeat (3) @(posedge clk_sys);
            rd(8'h0F, 8'hFF);
            rd(8'h0E, 8'hA7);
            wait_done();
            rd(8'h0F, 8'hFF);
            rd(8'h0E, 8'hA7);
            rd(8'h11, 8'hFF);
            rd(8'h12, 8'hFF);
            chk(cap_array_r, cap_calc + tr);
        end
        acc(1'b1, 8'h0E, 8'h07);
        for (i = 0; i < 2; i++)
        begin
            {alarm2_match, alarm1_match} <= 2'(1 << i);
            @(posedge clk_sys);
            {alarm2_match, alarm1_match} <= 2'b00;
            st = st | 8'(1 << i);
            repeat (2) @(posedge clk_sys);
            chk({7'h00, irq_or_wave_oe_n_r}, 8'h00);
            acc(1'b1, 8'h0F, 8'h0B);
            rd(8'h0F, 8'hFF);
            acc(1'b1, 8'h0F, 8'h08);
            rd(8'h0F, 8'hFF);
        end
        acc(1'b1, 8'h0E, 8'h00);
        @(posedge clk_sys);
        chk({7'h00, irq_or_wave_oe_n_r}, {7'h00, ~sqw_src});
        chk({7'h00, irq_or_wave_pin_r}, 8'h00);
        osc_fail <= 1'b1;
        repeat (20) @(posedge clk_sys);
        osc_fail <= 1'b0;
        st = st | 8'h80;
        repeat (20) @(posedge clk_sys);
        rd(8'h0F, 8'hFF);
        acc(1'b1, 8'h0F, 8'h00);
        toggles();
        chk(8'(t), 8'h00);
        on_battery <= 1'b1;
        acc(1'b1, 8'h0F, 8'h48);
        toggles();
        chk(8'(t > 0), 8'h01);
        acc(1'b1, 8'h0F, 8'h08);
        toggles();
        chk(8'(t), 8'h00);
        acc(1'b1, 8'h0E, 8'h84);
        repeat (20) @(posedge clk_sys);
        st = st | 8'h80;
        chk({7'h00, osc_run_r}, 8'h00);
        rd(8'h0F, 8'hFB);
        on_battery <= 1'b0;
        acc(1'b1, 8'h0E, 8'h84);
        repeat (60) @(posedge clk_sys);
        chk({7'h00, osc_run_r}, 8'h01);
        give_verdict();
    end
endmodule // rtcsr_regs_bench
